// ===== hdl/wcm_monitor.sv
// Weld cycle alarm monitor: raises, latches and clears cycle alarms.
//
// Functional notes
// - Warnings are reported, never abort the cycle.
// - Step enabled, not reached at end: E4:04.
// - Cycle run with sonics disable active: E4:05.
// - Afterburst phase out for set time: E4:11.
// - Afterburst current/power/voltage peak: E4:12/14/15.
// - Afterburst frequency outside window: E4:13.
// - Afterburst heat sink over threshold: E4:16.
// - Temperature alarm clear refused while still hot.
// - Limit alarms only at weld end, no abort.
// - Peak power under/over limit: E5:03/E5:04.
// - Weld time under/over limit: E5:05/E5:06.
// - Weld energy under/over limit: E5:07/E5:08.
// - Equipment alarms block start, hold while fault.
// - Start/trigger held over 4 s: E6:01.
// - Trigger with upper switch anytime: E6:02.
// - Actuator, ready, trigger active: E6:03.
// - Actuator, ready, upper switch off: E6:04.
// - Ground detect in ready: E6:05.
// - Cable detect enabled, no voltage: E6:07.
// - Start removed before trigger: E6:09.
// - Cycle abort in ready: E6:10.
// - Upper switch return timeout at end: E6:11.
`timescale 1ns/100ps
module wcm_monitor
	import wcm_pkg::*;
#(
	parameter int START_HOLD_CYC = START_HOLD_MS * CLK_KHZ,
	parameter int ULS_TIMEOUT_CYC = ULS_TIMEOUT_MS * CLK_KHZ
) (
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	// Cycle phase from the weld sequencer.
	input wire logic i_ready,
	input wire logic i_wait_ready,
	input wire logic i_afterburst,
	input wire logic i_cycle_end,
	input wire logic i_actuator_present,
	// Discrete machine inputs.
	input wire logic i_start,
	input wire logic i_trigger,
	input wire logic i_upper_limit_switch_input,
	input wire logic i_ground_detect,
	input wire logic i_cycle_abort,
	input wire logic i_sonics_disable,
	input wire logic i_cable_detect,
	// Feature enables.
	input wire logic i_sonics_disable_en,
	input wire logic i_cable_detect_en,
	input wire logic i_amp_step_en,
	input wire logic i_amp_step_done,
	// Afterburst measurements and peak limits.
	input wire logic i_phase_out,
	input wire logic [TMR_W-1:0] i_phase_limit_cyc,
	input wire logic [MEAS_W-1:0] i_current,
	input wire logic [MEAS_W-1:0] i_current_pk_lim,
	input wire logic [MEAS_W-1:0] i_power,
	input wire logic [MEAS_W-1:0] i_power_pk_lim,
	input wire logic [MEAS_W-1:0] i_voltage,
	input wire logic [MEAS_W-1:0] i_voltage_pk_lim,
	input wire logic [MEAS_W-1:0] i_freq,
	input wire logic [MEAS_W-1:0] i_freq_lo,
	input wire logic [MEAS_W-1:0] i_freq_hi,
	input wire logic [MEAS_W-1:0] i_temp,
	input wire logic [MEAS_W-1:0] i_temp_lim,
	// End of weld results and limits.
	input wire logic [MEAS_W-1:0] i_weld_peak_power,
	input wire logic [MEAS_W-1:0] i_power_minus,
	input wire logic [MEAS_W-1:0] i_power_plus,
	input wire logic [MEAS_W-1:0] i_weld_time,
	input wire logic [MEAS_W-1:0] i_time_minus,
	input wire logic [MEAS_W-1:0] i_time_plus,
	input wire logic [MEAS_W-1:0] i_weld_energy,
	input wire logic [MEAS_W-1:0] i_energy_minus,
	input wire logic [MEAS_W-1:0] i_energy_plus,
	// Alarm clear request, one cycle pulse.
	input wire logic i_alarm_clear,
	// Alarm status.
	output logic [NUM_ALARMS-1:0] o_alarms,
	output logic [3:0] o_alarm_group,
	output logic [7:0] o_alarm_number,
	output logic o_alarm_valid,
	output logic o_start_block
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	wcm_alarm_if abus(); // Carrier to the encoder.
	wcm_state_e st_reg; // Cycle tracker state.
	wcm_state_e st_next;
	logic [NUM_ALARMS-1:0] alarm_reg; // Latched alarms.
	logic [NUM_ALARMS-1:0] alarm_next;
	logic [NUM_ALARMS-1:0] set_vec; // Raise conditions this cycle.
	logic [NUM_ALARMS-1:0] clr_vec; // Bits a clear may drop.
	logic [NUM_ALARMS-1:0] hold_vec; // Bits a clear may not drop.
	logic in_ready; // Ready with the sequencer's consent.
	logic temp_hot; // Heat sink at or over threshold.
	logic ph_expired; // Phase out of limit long enough.
	logic hold_run; // Start or trigger held outside ready.
	logic hold_expired;
	logic uls_run; // Waiting for the upper switch to return.
	logic uls_expired;
	logic st_idle;
	logic st_armed;
	logic st_weld;
	logic st_return;

	// ----------------------------------------------------------------
	// Cycle tracker
	// ----------------------------------------------------------------
	assign st_idle = st_reg == ST_IDLE;
	assign st_armed = st_reg == ST_ARMED;
	assign st_weld = st_reg == ST_WELD;
	assign st_return = st_reg == ST_RETURN;
	assign in_ready = i_ready;

	// Follows start, trigger and end so sequence alarms know the phase.
	always_comb begin
		case (st_reg)
			ST_IDLE: begin
				st_next = (in_ready && i_start) ? ST_ARMED : ST_IDLE;
			end
			ST_ARMED: begin
				if (i_trigger) begin
					st_next = ST_WELD;
				end else if (!i_start) begin
					st_next = ST_IDLE;
				end else begin
					st_next = ST_ARMED;
				end
			end
			ST_WELD: begin
				st_next = i_cycle_end ? ST_RETURN : ST_WELD;
			end
			ST_RETURN: begin
				// Without an actuator there is no switch to wait for.
				if (i_upper_limit_switch_input || !i_actuator_present) begin
					st_next = ST_IDLE;
				end else begin
					st_next = ST_RETURN;
				end
			end
			default: begin
				st_next = ST_IDLE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			st_reg <= ST_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// Timers
	// ----------------------------------------------------------------
	// Held start counts only outside ready; in ready it is a real start.
	assign hold_run = (i_start || i_trigger) && !in_ready
		&& (st_idle || st_return || i_wait_ready);
	assign uls_run = st_return && i_actuator_present && !i_upper_limit_switch_input;

	// Phase out of window for the configured duration.
	wcm_timer u_phase_tmr (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_run(i_afterburst && i_phase_out),
		.i_limit(i_phase_limit_cyc),
		.o_expired(ph_expired)
	);

	// Start or trigger held too long outside ready.
	wcm_timer u_hold_tmr (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_run(hold_run),
		.i_limit(TMR_W'(START_HOLD_CYC)),
		.o_expired(hold_expired)
	);

	// Upper switch return at the end of the cycle.
	wcm_timer u_uls_tmr (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_run(uls_run),
		.i_limit(TMR_W'(ULS_TIMEOUT_CYC)),
		.o_expired(uls_expired)
	);

	// ----------------------------------------------------------------
	// Raise conditions
	// ----------------------------------------------------------------
	// Warnings only feed the latches; nothing here stops the weld.
	assign set_vec[A_STEP] = i_cycle_end && i_amp_step_en && !i_amp_step_done;
	assign set_vec[A_SONICS_DIS] = st_weld && i_sonics_disable_en && i_sonics_disable;
	assign set_vec[A_AB_PHASE] = ph_expired;
	assign set_vec[A_AB_CURR] = i_afterburst && !f_below(i_current, i_current_pk_lim);
	assign set_vec[A_AB_FREQ] = i_afterburst
		&& (f_below(i_freq, i_freq_lo) || f_above(i_freq, i_freq_hi));
	assign set_vec[A_AB_POWER] = i_afterburst && !f_below(i_power, i_power_pk_lim);
	assign set_vec[A_AB_VOLT] = i_afterburst && !f_below(i_voltage, i_voltage_pk_lim);
	assign set_vec[A_AB_TEMP] = i_afterburst && f_above(i_temp, i_temp_lim);
	// Limits are judged on the end pulse only and never stop sonics.
	assign set_vec[A_PWR_MIN] = i_cycle_end && f_below(i_weld_peak_power, i_power_minus);
	assign set_vec[A_PWR_MAX] = i_cycle_end && f_above(i_weld_peak_power, i_power_plus);
	assign set_vec[A_TIME_MIN] = i_cycle_end && f_below(i_weld_time, i_time_minus);
	assign set_vec[A_TIME_MAX] = i_cycle_end && f_above(i_weld_time, i_time_plus);
	assign set_vec[A_NRG_MIN] = i_cycle_end && f_below(i_weld_energy, i_energy_minus);
	assign set_vec[A_NRG_MAX] = i_cycle_end && f_above(i_weld_energy, i_energy_plus);
	assign set_vec[A_START_HELD] = hold_expired;
	assign set_vec[A_TRIG_ULS] = i_trigger && i_upper_limit_switch_input;
	assign set_vec[A_TRIG_READY] = i_actuator_present && in_ready && i_trigger;
	assign set_vec[A_ULS_READY] = i_actuator_present && in_ready
		&& !i_upper_limit_switch_input;
	assign set_vec[A_GND_READY] = in_ready && i_ground_detect;
	assign set_vec[A_CABLE] = i_cable_detect_en && !i_cable_detect;
	assign set_vec[A_START_LOST] = st_armed && !i_start && !i_trigger;
	assign set_vec[A_ABORT_READY] = in_ready && i_cycle_abort;
	assign set_vec[A_ULS_TOUT] = uls_expired;

	// ----------------------------------------------------------------
	// Latches and clear
	// ----------------------------------------------------------------
	// The temperature bit may not drop while the sink is still hot.
	assign temp_hot = !f_below(i_temp, i_temp_lim);
	assign hold_vec = NUM_ALARMS'(temp_hot) << A_AB_TEMP;
	assign clr_vec = i_alarm_clear ? ~hold_vec : '0;
	// Set wins over clear, so a live equipment fault survives a clear.
	assign alarm_next = set_vec | (alarm_reg & ~clr_vec);

	// Alarm latches.
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			alarm_reg <= '0;
		end else begin
			alarm_reg <= alarm_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign abus.alarms = alarm_reg;
	assign o_alarms = alarm_reg;
	assign o_alarm_group = abus.code[11:8];
	assign o_alarm_number = abus.code[7:0];
	assign o_alarm_valid = abus.valid;
	// Any latched equipment alarm holds off the next start.
	assign o_start_block = |(alarm_reg & G6_MASK);

	// Code encoder.
	wcm_code_enc u_enc (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.bus(abus.enc)
	);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);

	step_missed_a: assert property (i_cycle_end && i_amp_step_en && !i_amp_step_done
		|=> alarm_reg[A_STEP]) else $error("step alarm not raised");
	sonics_off_a: assert property (st_weld && i_sonics_disable_en && i_sonics_disable
		|=> alarm_reg[A_SONICS_DIS]) else $error("sonics disable alarm missing");
	phase_time_a: assert property (i_afterburst && i_phase_out && i_phase_limit_cyc == 2
		[*3] |=> alarm_reg[A_AB_PHASE]) else $error("phase duration alarm missing");
	peak_curr_a: assert property (i_afterburst && i_current >= i_current_pk_lim
		|=> alarm_reg[A_AB_CURR]) else $error("current peak alarm missing");
	freq_window_a: assert property (i_afterburst && i_freq > i_freq_hi
		|=> alarm_reg[A_AB_FREQ]) else $error("frequency alarm missing");
	temp_hold_a: assert property (alarm_reg[A_AB_TEMP] && i_temp >= i_temp_lim
		|=> alarm_reg[A_AB_TEMP]) else $error("hot temperature alarm cleared");
	power_limit_a: assert property (i_cycle_end && i_weld_peak_power < i_power_minus
		|=> alarm_reg[A_PWR_MIN]) else $error("power minus alarm missing");
	limit_end_a: assert property (!i_cycle_end && !alarm_reg[A_TIME_MAX]
		|=> !alarm_reg[A_TIME_MAX]) else $error("time limit raised mid weld");
	block_start_a: assert property (i_cable_detect_en && !i_cable_detect
		|=> o_start_block) else $error("start not blocked");
	trig_uls_a: assert property (i_trigger && i_upper_limit_switch_input
		|=> alarm_reg[A_TRIG_ULS] && o_start_block) else $error("trigger/uls missing");
	start_lost_a: assert property (st_armed && !i_start && !i_trigger
		|=> alarm_reg[A_START_LOST] ##1 o_alarm_valid) else $error("start lost missing");
	code_show_a: assert property (alarm_reg == 23'h000001
		|=> o_alarm_group == 4'h4 && o_alarm_number == 8'h04) else $error("bad code");

	ret_seen_c: cover property (st_weld ##1 st_return ##[1:20] st_idle);
	blocked_c: cover property (o_start_block && i_alarm_clear);
	hot_clear_c: cover property (alarm_reg[A_AB_TEMP] && temp_hot && i_alarm_clear);
	limit_c: cover property (i_cycle_end && set_vec[A_NRG_MAX]);
endmodule // wcm_monitor

// ===== hdl/wcm_pkg.sv
// Shared constants, alarm table and helpers for the weld cycle alarm monitor.
package wcm_pkg;

	// ----------------------------------------------------------------
	// Widths and timing
	// ----------------------------------------------------------------
	localparam int MEAS_W = 16; // Width of every measured quantity and limit.
	localparam int TMR_W = 28; // Timer width, enough for several seconds.
	localparam int CLK_KHZ = 40000; // System clock rate in kHz.
	localparam int START_HOLD_MS = 4000; // Start or trigger held outside ready, ms.
	localparam int ULS_TIMEOUT_MS = 2000; // Upper switch return timeout, ms.

	// ----------------------------------------------------------------
	// Alarm bit positions
	// ----------------------------------------------------------------
	localparam int NUM_ALARMS = 23;
	localparam int A_STEP = 0; // Amplitude step not reached.
	localparam int A_SONICS_DIS = 1; // Sonics disabled by user input.
	localparam int A_AB_PHASE = 2; // Afterburst phase overload.
	localparam int A_AB_CURR = 3; // Afterburst current overload.
	localparam int A_AB_FREQ = 4; // Afterburst frequency overload.
	localparam int A_AB_POWER = 5; // Afterburst power overload.
	localparam int A_AB_VOLT = 6; // Afterburst voltage overload.
	localparam int A_AB_TEMP = 7; // Afterburst temperature overload.
	localparam int A_PWR_MIN = 8; // Peak power under minus limit.
	localparam int A_PWR_MAX = 9; // Peak power over plus limit.
	localparam int A_TIME_MIN = 10; // Weld time under minus limit.
	localparam int A_TIME_MAX = 11; // Weld time over plus limit.
	localparam int A_NRG_MIN = 12; // Weld energy under minus limit.
	localparam int A_NRG_MAX = 13; // Weld energy over plus limit.
	localparam int A_START_HELD = 14; // Start or trigger still active.
	localparam int A_TRIG_ULS = 15; // Trigger together with upper switch.
	localparam int A_TRIG_READY = 16; // Trigger active in ready.
	localparam int A_ULS_READY = 17; // Upper switch not active in ready.
	localparam int A_GND_READY = 18; // Ground detect active in ready.
	localparam int A_CABLE = 19; // Cable detect pin has no voltage.
	localparam int A_START_LOST = 20; // Start removed before trigger.
	localparam int A_ABORT_READY = 21; // Cycle abort active in ready.
	localparam int A_ULS_TOUT = 22; // Upper switch return timeout.

	// Bits of the equipment failure group, which block cycle start.
	localparam logic [NUM_ALARMS-1:0] G6_MASK = 23'h7fc000;

	// Code per bit: group digit in [11:8], two BCD digits in [7:0].
	localparam logic [11:0] NO_CODE = 12'h000;
	localparam logic [11:0] ALARM_CODE [NUM_ALARMS] = '{
		12'h404, 12'h405, 12'h411, 12'h412, 12'h413, 12'h414, 12'h415, 12'h416,
		12'h503, 12'h504, 12'h505, 12'h506, 12'h507, 12'h508,
		12'h601, 12'h602, 12'h603, 12'h604, 12'h605, 12'h607, 12'h609, 12'h610,
		12'h611};

	// Cycle tracker states, one-hot.
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ARMED = 4'h2,
		ST_WELD = 4'h4,
		ST_RETURN = 4'h8
	} wcm_state_e;

	// Strictly above a limit.
	function automatic logic f_above(input logic [MEAS_W-1:0] v, input logic [MEAS_W-1:0] lim);
		return v > lim;
	endfunction

	// Strictly below a limit.
	function automatic logic f_below(input logic [MEAS_W-1:0] v, input logic [MEAS_W-1:0] lim);
		return v < lim;
	endfunction

endpackage

// ===== hdl/wcm_alarm_if.sv
// Carrier between the alarm latches and the code encoder.
`timescale 1ns/100ps
interface wcm_alarm_if;
	import wcm_pkg::*;
	logic [NUM_ALARMS-1:0] alarms; // Latched alarm bits.
	logic [11:0] code; // Code of the most important latched alarm.
	logic valid; // Some alarm is latched.
	modport src (output alarms, input code, input valid);
	modport enc (input alarms, output code, output valid);
endinterface // wcm_alarm_if

// ===== hdl/wcm_timer.sv
// Saturating run-time counter that flags when a level has lasted long enough.
`timescale 1ns/100ps
module wcm_timer
	import wcm_pkg::*;
(
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	// Control.
	input wire logic i_run,
	input wire logic [TMR_W-1:0] i_limit,
	// Status.
	output logic o_expired
);
	logic [TMR_W-1:0] cnt_reg; // Cycles the run level has lasted.
	logic [TMR_W-1:0] cnt_next;
	logic at_limit;

	// Saturate at the limit so a long fault never wraps the count.
	assign at_limit = cnt_reg >= i_limit;
	assign cnt_next = !i_run ? '0 : (at_limit ? cnt_reg : cnt_reg + 1'b1);
	assign o_expired = i_run && at_limit;

	// Count while running, restart from zero whenever the level drops.
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
endmodule // wcm_timer

// ===== hdl/wcm_code_enc.sv
// Picks the lowest latched alarm and presents its group and number.
`timescale 1ns/100ps
module wcm_code_enc
	import wcm_pkg::*;
(
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	// Alarm carrier.
	wcm_alarm_if.enc bus
);
	logic [11:0] code_next; // Selected code before the register.

	// Lowest bit wins: warnings first, then limits, then equipment.
	always_comb begin
		code_next = NO_CODE;
		for (int i = NUM_ALARMS - 1; i >= 0; i--) begin
			if (bus.alarms[i]) begin
				code_next = ALARM_CODE[i];
			end
		end
	end

	// Registered so the displayed code never glitches.
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			bus.code <= NO_CODE;
			bus.valid <= 1'b0;
		end else begin
			bus.code <= code_next;
			bus.valid <= |bus.alarms;
		end
	end
endmodule // wcm_code_enc

// ===== verification/wcm_machine_model.sv
// Machine side model: switch and user input levels seen by the alarm monitor.
`timescale 1ns/100ps
module wcm_machine_model (
	// Actuator and cycle switches.
	output logic o_start,
	output logic o_trigger,
	output logic o_upper_limit_switch_input,
	output logic o_ground_detect,
	output logic o_cycle_abort,
	// User input pins.
	output logic o_sonics_disable,
	output logic o_cable_detect
);
	// ----------------------------------------------------------------
	// Level control
	// ----------------------------------------------------------------
	// The cable pin starts powered, as on a healthy harness.
	initial begin
		put(7'h01);
	end

	// All levels move together; the caller calls this just after a clock edge.
	// Order of bits: start, trigger, upper switch, ground, abort, sonics off, cable.
	task automatic put(input logic [6:0] v);
		{o_start, o_trigger, o_upper_limit_switch_input, o_ground_detect,
			o_cycle_abort, o_sonics_disable, o_cable_detect} = v;
	endtask
endmodule // wcm_machine_model

// ===== verification/testbench.sv
// Self-checking testbench for the weld cycle alarm monitor.
`timescale 1ns/100ps
module testbench;
	import wcm_pkg::*;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic clk = 1'b0, resetn = 1'b0, rdy = 1'b0, wrdy = 1'b0, ab = 1'b0, cend = 1'b0;
	logic act = 1'b0, sd_en = 1'b0, cab_en = 1'b0, stp_en = 1'b0, stp_done = 1'b0;
	logic ph_out = 1'b0, clr = 1'b0;
	logic [TMR_W-1:0] ph_lim = 28'h5;
	logic [15:0] cur = 16'h10, pwr = 16'h10, vlt = 16'h10, lim = 16'h32;
	logic [15:0] frq = 16'h96, flo = 16'h64, fhi = 16'hc8, tmp = 16'h40, tlim = 16'h50;
	logic [15:0] wpk = 16'h96, wt = 16'h96, we = 16'h96, mn = 16'h64, pl = 16'hc8;
	logic m_st, m_tr, m_uls, m_gnd, m_ab, m_sd, m_cab, val, blk;
	logic [NUM_ALARMS-1:0] alarms;
	logic [3:0] grp;
	logic [7:0] num;
	int n_mismatch = 0, checks = 0;

	// Clock at 40 MHz.
	always #12.5 clk = ~clk;

	// ----------------------------------------------------------------
	// Devices
	// ----------------------------------------------------------------
	wcm_machine_model u_wcm_machine_model (.o_start(m_st), .o_trigger(m_tr),
		.o_upper_limit_switch_input(m_uls), .o_ground_detect(m_gnd), .o_cycle_abort(m_ab),
		.o_sonics_disable(m_sd), .o_cable_detect(m_cab));

	// Short timers keep the run brief; expectations below use these values.
	wcm_monitor #(.START_HOLD_CYC(20), .ULS_TIMEOUT_CYC(30)) u_wcm_monitor (
		.i_clk_sys(clk), .i_resetn(resetn), .i_ready(rdy), .i_wait_ready(wrdy),
		.i_afterburst(ab), .i_cycle_end(cend), .i_actuator_present(act), .i_start(m_st),
		.i_trigger(m_tr), .i_upper_limit_switch_input(m_uls), .i_ground_detect(m_gnd),
		.i_cycle_abort(m_ab), .i_sonics_disable(m_sd), .i_cable_detect(m_cab),
		.i_sonics_disable_en(sd_en), .i_cable_detect_en(cab_en), .i_amp_step_en(stp_en),
		.i_amp_step_done(stp_done), .i_phase_out(ph_out), .i_phase_limit_cyc(ph_lim),
		.i_current(cur), .i_current_pk_lim(lim), .i_power(pwr), .i_power_pk_lim(lim),
		.i_voltage(vlt), .i_voltage_pk_lim(lim), .i_freq(frq), .i_freq_lo(flo),
		.i_freq_hi(fhi), .i_temp(tmp), .i_temp_lim(tlim), .i_weld_peak_power(wpk),
		.i_power_minus(mn), .i_power_plus(pl), .i_weld_time(wt), .i_time_minus(mn),
		.i_time_plus(pl), .i_weld_energy(we), .i_energy_minus(mn), .i_energy_plus(pl),
		.i_alarm_clear(clr), .o_alarms(alarms), .o_alarm_group(grp), .o_alarm_number(num),
		.o_alarm_valid(val), .o_start_block(blk));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	// Waits n edges, then steps past the edge so drives never race it.
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	// Compares the latched alarm vector.
	task automatic chk_a(input string s, input logic [22:0] e);
		checks++;
		if (alarms !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", s, e, alarms);
		end
	endtask

	// Compares group and number together; valid must follow a non-zero code.
	task automatic chk_c(input string s, input logic [11:0] e);
		checks++;
		if ({grp, num} !== e || val !== (e != 12'h000)) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", s, e, {grp, num});
		end
	endtask

	// Compares the start block flag.
	task automatic chk_b(input string s, input logic e);
		checks++;
		if (blk !== e) begin
			n_mismatch++;
			$display("BAD %s exp %b got %b", s, e, blk);
		end
	endtask

	// One-cycle clear request.
	task automatic clear;
		clr = 1'b1;
		cyc(1);
		clr = 1'b0;
	endtask

	// End of weld with given results; then the results are made good again.
	task automatic lim_case(input logic [15:0] p, t, e, input logic [22:0] x,
		input logic [11:0] c);
		wpk = p;
		wt = t;
		we = e;
		cend = 1'b1;
		cyc(1);
		cend = 1'b0;
		{wpk, wt, we} = {3{16'h96}};
		cyc(1);
		chk_a("limit", x);
		chk_c("limit code", c);
		chk_b("limit block", 1'b0);
		clear;
		chk_a("limit cleared", 23'h0);
	endtask

	// Afterburst measurements; good values are restored before the clear.
	task automatic ab_case(input logic [15:0] c, p, v, f, input logic [22:0] x);
		ab = 1'b1;
		{cur, pwr, vlt, frq} = {c, p, v, f};
		cyc(2);
		chk_a("afterburst", x);
		chk_b("afterburst block", 1'b0);
		{cur, pwr, vlt, frq} = {16'h10, 16'h10, 16'h10, 16'h96};
		ab = 1'b0;
		clear;
		chk_a("afterburst cleared", 23'h0);
	endtask

	// Equipment fault held, clear refused while live, then removed and cleared.
	task automatic eq(input logic r, ce, input logic [6:0] m, input logic [22:0] x);
		rdy = r;
		cab_en = ce;
		u_wcm_machine_model.put(m);
		cyc(3);
		chk_a("equipment", x);
		chk_b("equipment block", 1'b1);
		clear;
		chk_a("equipment held", x);
		rdy = 1'b0;
		cab_en = 1'b0;
		u_wcm_machine_model.put(7'h01);
		cyc(2);
		clear;
		chk_a("equipment cleared", 23'h0);
		chk_b("block released", 1'b0);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	// The sequence needs about 200 cycles; 4000 leaves a wide margin.
	initial begin
		#(25 * 4000);
		n_mismatch++;
		$display("BAD watchdog exp done got hang");
		end_sim;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		chk_a("reset alarms", 23'h0);
		chk_c("reset code", 12'h000);
		#2;
		resetn = 1'b1;
		cyc(2);
		// Limit alarms: each bound on both sides, and a value on the bound.
		lim_case(16'h63, 16'h96, 16'h96, 23'h000100, 12'h503);
		lim_case(16'hc9, 16'h96, 16'h96, 23'h000200, 12'h504);
		lim_case(16'h96, 16'h63, 16'h96, 23'h000400, 12'h505);
		lim_case(16'h96, 16'hc9, 16'h96, 23'h000800, 12'h506);
		lim_case(16'h96, 16'h96, 16'h63, 23'h001000, 12'h507);
		lim_case(16'h96, 16'h96, 16'hc9, 23'h002000, 12'h508);
		lim_case(16'h64, 16'hc8, 16'h64, 23'h0, 12'h000);
		// Bad results without an end of weld raise nothing.
		wt = 16'h01;
		cyc(3);
		chk_a("no end", 23'h0);
		wt = 16'h96;
		// Step enabled and missed, then reached.
		stp_en = 1'b1;
		lim_case(16'h96, 16'h96, 16'h96, 23'h000001, 12'h404);
		stp_done = 1'b1;
		lim_case(16'h96, 16'h96, 16'h96, 23'h0, 12'h000);
		stp_en = 1'b0;
		// Tighter minus, then plus limits flag all three results at once.
		mn = 16'h97;
		lim_case(16'h96, 16'h96, 16'h96, 23'h001500, 12'h503);
		{mn, pl} = {16'h64, 16'h95};
		lim_case(16'h96, 16'h96, 16'h96, 23'h002a00, 12'h504);
		pl = 16'hc8;
		// Afterburst peaks reached exactly, and frequency just outside.
		ab_case(16'h32, 16'h10, 16'h10, 16'h96, 23'h000008);
		ab_case(16'h10, 16'h32, 16'h10, 16'h96, 23'h000020);
		ab_case(16'h10, 16'h10, 16'h32, 16'h96, 23'h000040);
		ab_case(16'h10, 16'h10, 16'h10, 16'h63, 23'h000010);
		ab_case(16'h10, 16'h10, 16'h10, 16'hc9, 23'h000010);
		// A raised peak limit lets the same values pass.
		lim = 16'h33;
		ab_case(16'h32, 16'h32, 16'h32, 16'h96, 23'h0);
		lim = 16'h32;
		// Temperature: equal is no alarm, above is; clear refused until cool.
		ab = 1'b1;
		tmp = 16'h50;
		cyc(2);
		chk_a("temp equal", 23'h0);
		tmp = 16'h51;
		cyc(2);
		chk_a("temp over", 23'h000080);
		ab = 1'b0;
		tmp = 16'h50;
		clear;
		chk_a("temp clear refused", 23'h000080);
		tmp = 16'h4f;
		clear;
		chk_a("temp cleared", 23'h0);
		// Phase out must last the set time before it counts.
		ab = 1'b1;
		ph_out = 1'b1;
		cyc(4);
		chk_a("phase short", 23'h0);
		cyc(4);
		chk_a("phase long", 23'h000004);
		// A shorter set time counts from a fresh phase excursion.
		ph_out = 1'b0;
		ph_lim = 28'h2;
		clear;
		ph_out = 1'b1;
		cyc(2);
		chk_a("phase short 2", 23'h0);
		cyc(1);
		chk_a("phase long 2", 23'h000004);
		ph_out = 1'b0;
		ab = 1'b0;
		clear;
		act = 1'b1;
		// Equipment faults one at a time; the fifth, trigger with upper switch in ready, raises two together.
		eq(1'b0, 1'b0, 7'h31, 23'h008000);
		eq(1'b1, 1'b0, 7'h01, 23'h020000);
		eq(1'b1, 1'b0, 7'h19, 23'h040000);
		eq(1'b1, 1'b0, 7'h15, 23'h200000);
		eq(1'b1, 1'b0, 7'h31, 23'h018000);
		eq(1'b0, 1'b1, 7'h00, 23'h080000);
		// Start held outside ready: alarm only after the hold time.
		u_wcm_machine_model.put(7'h41);
		cyc(10);
		chk_a("hold short", 23'h0);
		cyc(15);
		chk_a("hold long", 23'h004000);
		u_wcm_machine_model.put(7'h01);
		cyc(1);
		clear;
		// Armed in ready, start removed before the trigger.
		rdy = 1'b1;
		u_wcm_machine_model.put(7'h51);
		cyc(1);
		u_wcm_machine_model.put(7'h11);
		cyc(2);
		chk_a("start lost", 23'h100000);
		rdy = 1'b0;
		u_wcm_machine_model.put(7'h01);
		clear;
		chk_a("start lost cleared", 23'h0);
		// Full weld with sonics disabled, then the switch returns only after its timeout.
		sd_en = 1'b1;
		rdy = 1'b1;
		u_wcm_machine_model.put(7'h51);
		cyc(1);
		rdy = 1'b0;
		u_wcm_machine_model.put(7'h63);
		cyc(3);
		chk_a("sonics off", 23'h000002);
		chk_b("warning no block", 1'b0);
		cend = 1'b1;
		cyc(1);
		cend = 1'b0;
		u_wcm_machine_model.put(7'h01);
		cyc(2);
		chk_c("warning code", 12'h405);
		cyc(35);
		chk_a("switch timeout", 23'h400002);
		chk_c("priority code", 12'h405);
		chk_b("timeout block", 1'b1);
		u_wcm_machine_model.put(7'h11);
		sd_en = 1'b0;
		cyc(1);
		clear;
		cyc(1);
		chk_a("all cleared", 23'h0);
		end_sim;
	end
endmodule // testbench
